// ---- design/jcp_top.sv ----
`timescale 1ns/100ps
`include "jcp_cfg.svh"
module jcp_top (
	input  wire logic                MCLK,
	input  wire logic                ARST_N,
	input  wire logic                TCK,
	input  wire logic                TMS,
	input  wire logic                TDI,
	output logic                     TDO,
	output logic                     TDO_OE,
	input  wire logic                CHIP_SELECT_LOW,
	input  wire logic [`JCP_BSR_W-1:0] PIN_IN,
	input  wire logic                PS_LOAD_ACTIVE,
	output logic                     PS_ABORT,
	output logic                     ACTIVE_IDLE,
	output logic                     USER_IO_HIZ,
	output logic                     CONFIG_STATUS_LOW,
	output logic                     LOAD_COMPLETE_FLAG,
	output logic                     USER_MODE
);
	import jcp_pkg::*;

	logic [2:0] tck_s;
	logic [1:0] tms_s;
	logic [1:0] tdi_s;
	logic [1:0] ce_s;
	logic [1:0] ps_s;
	logic       rise;
	logic       fall;
	jcp_state_t state;
	logic [`JCP_IR_W-1:0] ir_sh;
	logic [`JCP_IR_W-1:0] ir;
	logic       bypass_bit;
	logic [31:0] dr_sh;
	logic [1:0][`JCP_BSR_W-1:0] pin_s;
	logic [15:0] cfg_count;
	logic       loaded;
	logic [11:0] init_count;
	logic       done;
	logic       disengaged;
	logic       io_prog;
	logic       programming;
	logic       tdo_bit;
	logic       shifting;

	// Two stages per pin before use; a third stage on the clock finds edges
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tck_s <= 3'h0;
			tms_s <= 2'h3;
			tdi_s <= 2'h3;
			ce_s  <= 2'h3;
			ps_s  <= 2'h0;
			pin_s <= '0;
		end else begin
			tck_s <= {tck_s[1:0], TCK};
			tms_s <= {tms_s[0], TMS};
			tdi_s <= {tdi_s[0], TDI};
			ce_s  <= {ce_s[0], CHIP_SELECT_LOW};
			ps_s  <= {ps_s[0], PS_LOAD_ACTIVE};
			pin_s <= {pin_s[0], PIN_IN};
		end
	end

	assign rise = tck_s[1] & ~tck_s[2];
	assign fall = ~tck_s[1] & tck_s[2];

	jcp_tap_fsm u_fsm (
		.clk    (MCLK),
		.arst_n (ARST_N),
		.step   (rise),
		.mode   (tms_s[1]),
		.state  (state)
	);

	// Instruction register; reset selects identify as the standard requires
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ir_sh <= `JCP_IR_CAPTURE;
			ir    <= `JCP_OP_IDCODE;
		end else if (rise) begin
			unique case (state)
				TLR:     ir <= `JCP_OP_IDCODE;
				CIR:     ir_sh <= `JCP_IR_CAPTURE;
				SIR:     ir_sh <= {tdi_s[1], ir_sh[`JCP_IR_W-1:1]};
				UIR:     ir <= ir_sh;
				default: ir_sh <= ir_sh;
			endcase
		end
	end

	// Data registers: bypass, identify, sample, check and program shift
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bypass_bit <= 1'b0;
			dr_sh      <= 32'h0;
		end else if (rise) begin
			if (state == CDR) begin
				bypass_bit <= 1'b0;
				unique case (ir)
					`JCP_OP_IDCODE:  dr_sh <= `JCP_IDCODE_VALUE;
					`JCP_OP_SAMPLE,
					`JCP_OP_EXTEST:  dr_sh <= {24'h0, pin_s[1]};
					`JCP_OP_CHECK:   dr_sh <= {31'h0, done};
					default:         dr_sh <= dr_sh;
				endcase
			end else if (state == SDR) begin
				bypass_bit <= tdi_s[1];
				dr_sh      <= {tdi_s[1], dr_sh[31:1]};
			end
		end
	end

	// Program bits are counted only while this opcode is the current one
	assign programming = (ir == `JCP_OP_PROGRAM);

	// Bitstream count, then initialization clocks run in the idle state
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cfg_count  <= 16'h0;
			loaded     <= 1'b0;
			init_count <= 12'h0;
			done       <= 1'b0;
		end else if (rise) begin
			if (state == SDR && programming && !ce_s[1] && !loaded) begin
				cfg_count <= cfg_count + 16'h1;
				loaded    <= (cfg_count == `JCP_CFG_BITS - 16'h1);
				done      <= 1'b0;
			end else if (loaded && !done && ir == `JCP_OP_STARTUP && state == RTI) begin
				init_count <= init_count + 12'h1;
				done       <= (init_count == `JCP_INIT_CYCLES - 12'h1);
			end
			if (state == UIR && ir_sh == `JCP_OP_PROGRAM) begin
				cfg_count  <= 16'h0;
				loaded     <= 1'b0;
				init_count <= 12'h0;
				done       <= 1'b0;
			end
		end
	end

	// Release and I/O-reprogram modes, changed only at instruction update
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			disengaged <= 1'b0;
			io_prog    <= 1'b0;
		end else if (rise && state == UIR) begin
			if (ir_sh == `JCP_OP_DISENGAGE) begin
				disengaged <= 1'b1;
			end else if (ir_sh == `JCP_OP_ENGAGE) begin
				disengaged <= 1'b0;
				io_prog    <= 1'b0;
			end else if (ir_sh == `JCP_OP_CONFIG_IO && disengaged) begin
				io_prog <= 1'b1;
			end
		end
	end

	always_comb begin
		shifting = (state == SDR) || (state == SIR);
		if (state == SIR) begin
			tdo_bit = ir_sh[0];
		end else if (ir == `JCP_OP_BYPASS) begin
			tdo_bit = bypass_bit;
		end else begin
			tdo_bit = dr_sh[0];
		end
	end

	// Output pin updates on falling edges only
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TDO    <= 1'b0;
			TDO_OE <= 1'b0;
		end else if (fall) begin
			TDO    <= tdo_bit;
			TDO_OE <= shifting;
		end
	end

	// Configuration-side outputs; sample and bypass leave them untouched
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PS_ABORT           <= 1'b0;
			ACTIVE_IDLE        <= 1'b0;
			USER_IO_HIZ        <= 1'b0;
			CONFIG_STATUS_LOW  <= 1'b0;
			LOAD_COMPLETE_FLAG <= 1'b0;
			USER_MODE          <= 1'b0;
		end else begin
			PS_ABORT           <= programming && ps_s[1];
			ACTIVE_IDLE        <= disengaged || programming;
			USER_IO_HIZ        <= programming || (loaded && !done);
			CONFIG_STATUS_LOW  <= 1'b0;
			LOAD_COMPLETE_FLAG <= done;
			USER_MODE          <= done && !io_prog;
		end
	end
endmodule

// ---- common/jcp_cfg.svh ----
`ifndef JCP_CFG_SVH
`define JCP_CFG_SVH

`define JCP_IR_W          4
`define JCP_IR_CAPTURE    4'h1
`define JCP_OP_EXTEST     4'h0
`define JCP_OP_SAMPLE     4'h5
`define JCP_OP_IDCODE     4'h6
`define JCP_OP_PROGRAM    4'h2
`define JCP_OP_STARTUP    4'h3
`define JCP_OP_CHECK      4'h4
`define JCP_OP_CONFIG_IO  4'hD
`define JCP_OP_DISENGAGE  4'hB
`define JCP_OP_ENGAGE     4'hC
`define JCP_OP_BYPASS     4'hF
`define JCP_IDCODE_VALUE  32'h1234_5679
`define JCP_BSR_W         8
`define JCP_INIT_CYCLES   12'hC6C
`define JCP_CFG_BITS      16'h0100

`endif

// ---- common/jcp_pkg.sv ----
package jcp_pkg;
	typedef enum logic [15:0] {
		TLR   = 16'h0001, RTI   = 16'h0002, SDRS  = 16'h0004, CDR   = 16'h0008,
		SDR   = 16'h0010, E1DR  = 16'h0020, PDR   = 16'h0040, E2DR  = 16'h0080,
		UDR   = 16'h0100, SIRS  = 16'h0200, CIR   = 16'h0400, SIR   = 16'h0800,
		E1IR  = 16'h1000, PIR   = 16'h2000, E2IR  = 16'h4000, UIR   = 16'h8000
	} jcp_state_t;
endpackage

// ---- design/jcp_tap_fsm.sv ----
`timescale 1ns/100ps
module jcp_tap_fsm (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                step,
	input  wire logic                mode,
	output jcp_pkg::jcp_state_t      state
);
	import jcp_pkg::*;
	jcp_state_t next_state;

	always_comb begin
		unique case (state)
			TLR:  next_state = mode ? TLR  : RTI;
			RTI:  next_state = mode ? SDRS : RTI;
			SDRS: next_state = mode ? SIRS : CDR;
			CDR:  next_state = mode ? E1DR : SDR;
			SDR:  next_state = mode ? E1DR : SDR;
			E1DR: next_state = mode ? UDR  : PDR;
			PDR:  next_state = mode ? E2DR : PDR;
			E2DR: next_state = mode ? UDR  : SDR;
			UDR:  next_state = mode ? SDRS : RTI;
			SIRS: next_state = mode ? TLR  : CIR;
			CIR:  next_state = mode ? E1IR : SIR;
			SIR:  next_state = mode ? E1IR : SIR;
			E1IR: next_state = mode ? UIR  : PIR;
			PIR:  next_state = mode ? E2IR : PIR;
			E2IR: next_state = mode ? UIR  : SIR;
			UIR:  next_state = mode ? SDRS : RTI;
			default: next_state = TLR;
		endcase
	end

	// Advances only on a sampled rising test-clock edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= TLR;
		end else if (step) begin
			state <= next_state;
		end
	end
endmodule

// ---- verification/jcp_chk.sv ----
`timescale 1ns/100ps
module jcp_chk (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic TCK,
	input wire logic TDO,
	input wire logic TDO_OE,
	input wire logic PS_LOAD_ACTIVE,
	input wire logic PS_ABORT,
	input wire logic CONFIG_STATUS_LOW,
	input wire logic LOAD_COMPLETE_FLAG,
	input wire logic USER_MODE
);
	logic       tck_q;
	logic [3:0] since_fall;
	logic [3:0] since_rise;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!ARST_N);
	// Cycles since the test clock pin last fell or rose, saturating
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tck_q <= 1'b0;
			since_fall <= 4'hF;
			since_rise <= 4'hF;
		end else begin
			tck_q <= TCK;
			since_fall <= (tck_q && !TCK) ? 4'h0 : since_fall + {3'h0, ~&since_fall};
			since_rise <= (!tck_q && TCK) ? 4'h0 : since_rise + {3'h0, ~&since_rise};
		end
	end
	sequence fell_lately;
		since_fall <= 4'h4;
	endsequence
	sequence rose_lately;
		since_rise <= 4'h4;
	endsequence
	a_tdo_on_fall: assert property ($changed(TDO) |-> fell_lately)
		else $error("TDO moved away from a TCK fall");
	a_oe_on_fall: assert property ($changed(TDO_OE) |-> fell_lately)
		else $error("TDO_OE moved away from a TCK fall");
	a_status_released: assert property (CONFIG_STATUS_LOW == 1'b0)
		else $error("status output pulled low");
	a_done_holds: assert property (LOAD_COMPLETE_FLAG && since_rise > 4'h4 |=> LOAD_COMPLETE_FLAG)
		else $error("load flag dropped");
	a_done_on_tck: assert property ($rose(LOAD_COMPLETE_FLAG) |-> rose_lately)
		else $error("load flag rose without TCK");
	a_abort_needs_ps: assert property ($rose(PS_ABORT) |-> $past(PS_LOAD_ACTIVE))
		else $error("abort without serial load");
	a_abort_drops: assert property ($fell(PS_LOAD_ACTIVE) |-> ##[1:4] !PS_ABORT)
		else $error("abort stuck high");
	a_user_after_done: assert property ($rose(USER_MODE) |-> LOAD_COMPLETE_FLAG)
		else $error("user mode before load flag");
endmodule
bind jcp_top jcp_chk jcp_chk_i (.MCLK(MCLK), .ARST_N(ARST_N), .TCK(TCK), .TDO(TDO),
	.TDO_OE(TDO_OE), .PS_LOAD_ACTIVE(PS_LOAD_ACTIVE), .PS_ABORT(PS_ABORT),
	.CONFIG_STATUS_LOW(CONFIG_STATUS_LOW), .LOAD_COMPLETE_FLAG(LOAD_COMPLETE_FLAG),
	.USER_MODE(USER_MODE));

// ---- verification/jcp_host.sv ----
`timescale 1ns/100ps
module jcp_host (
	input  wire logic mclk,
	input  wire logic tdo,
	input  wire logic tdo_oe,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One 800 ns TCK period; TDO read while high, long after the fall
	task automatic step(input logic ms, input logic di, output logic dout);
		tms <= ms;
		tdi <= di;
		@(posedge mclk);
		tck <= 1'b1;
		@(negedge mclk);
		dout = tdo_oe ? tdo : 1'bz;
		repeat (4) @(posedge mclk);
		tck <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`include "jcp_cfg.svh"
module tb;
	logic                  mclk = 1'b0;
	logic                  arst_n = 1'b0;
	logic                  cs_low = 1'b0;
	logic [`JCP_BSR_W-1:0] pin_in = 8'h00;
	logic                  ps_on = 1'b0;
	logic                  tck, tms, tdi, tdo, tdo_oe, abort, idle, hiz, stat, done, umode;
	logic [255:0]          dout;
	int                    fails = 0;
	int                    num_checks = 0;
	int                    cycles = 0;
	jcp_top jcp_top_i (.MCLK(mclk), .ARST_N(arst_n), .TCK(tck), .TMS(tms), .TDI(tdi),
		.TDO(tdo), .TDO_OE(tdo_oe), .CHIP_SELECT_LOW(cs_low), .PIN_IN(pin_in),
		.PS_LOAD_ACTIVE(ps_on), .PS_ABORT(abort), .ACTIVE_IDLE(idle), .USER_IO_HIZ(hiz),
		.CONFIG_STATUS_LOW(stat), .LOAD_COMPLETE_FLAG(done), .USER_MODE(umode));
	jcp_host jcp_host_i (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
	always #50 mclk = ~mclk;
	task automatic summarize();
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// From Run-Test/Idle through one scan and back; dout keeps what TDO gave
	task automatic scan(input logic ir, input int n, input logic [255:0] din);
		logic b;
		dout = 256'h0;
		jcp_host_i.step(1'b1, 1'b1, b);
		if (ir) begin
			jcp_host_i.step(1'b1, 1'b1, b);
		end
		jcp_host_i.step(1'b0, 1'b1, b);
		jcp_host_i.step(1'b0, 1'b1, b);
		for (int k = 0; k < n; k++) begin
			jcp_host_i.step(k == n - 1, din[k], b);
			dout[k] = b;
		end
		jcp_host_i.step(1'b1, 1'b1, b);
		jcp_host_i.step(1'b0, 1'b1, b);
	endtask
	task automatic load_ir(input logic [3:0] op);
		scan(1'b1, 4, {252'h0, op});
		chk(dout[3:0], `JCP_IR_CAPTURE);
	endtask
	task automatic t_idcode();
		logic b;
		jcp_host_i.step(1'b0, 1'b1, b);
		chk(tdo_oe, 1'b0);
		scan(1'b0, 32, 256'h0);
		chk(dout[31:0], `JCP_IDCODE_VALUE);
	endtask
	task automatic t_sample();
		ps_on <= 1'b1;
		pin_in <= 8'hC3;
		load_ir(`JCP_OP_SAMPLE);
		scan(1'b0, 8, 256'h0);
		chk(dout[7:0], 8'hC3);
		chk(abort, 1'b0);
	endtask
	task automatic t_bypass();
		load_ir(`JCP_OP_BYPASS);
		scan(1'b0, 8, 256'hB5);
		chk(dout[7:0], 8'h6A);
	endtask
	task automatic t_program();
		logic b;
		load_ir(`JCP_OP_DISENGAGE);
		chk(idle, 1'b1);
		load_ir(`JCP_OP_CONFIG_IO);
		chk(stat, 1'b0);
		load_ir(`JCP_OP_EXTEST);
		scan(1'b0, 8, 256'h0);
		chk(dout[7:0], 8'hC3);
		cs_low <= 1'b1;
		load_ir(`JCP_OP_PROGRAM);
		scan(1'b0, 256, {8{32'h96F0_3CA5}});
		load_ir(`JCP_OP_STARTUP);
		chk(hiz, 1'b0);
		cs_low <= 1'b0;
		load_ir(`JCP_OP_PROGRAM);
		chk(abort, 1'b1);
		chk(hiz, 1'b1);
		scan(1'b0, 256, {8{32'h96F0_3CA5}});
		load_ir(`JCP_OP_STARTUP);
		chk(done, 1'b0);
		chk(hiz, 1'b1);
		repeat (`JCP_INIT_CYCLES) begin
			jcp_host_i.step(1'b0, 1'b1, b);
		end
		chk(done, 1'b1);
		load_ir(`JCP_OP_CHECK);
		scan(1'b0, 1, 256'h0);
		chk(dout[0], 1'b1);
		chk(umode, 1'b0);
		load_ir(`JCP_OP_ENGAGE);
		chk(umode, 1'b1);
		chk(idle, 1'b0);
		ps_on <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_idcode();
		t_sample();
		t_bypass();
		t_program();
		summarize();
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			summarize();
		end
	end
endmodule
